// file: verilog/seu_pkg.sv
`default_nettype none
package seu_pkg;
    // ----------------------------------------
    // register indices (byte address = 4 x index)
    // ----------------------------------------
    localparam logic [15:0] IDX_BREAK_STATUS = 16'hfe00;
    localparam logic [15:0] IDX_RESET_SOURCE_STATUS = 16'hfe01;
    localparam logic [15:0] IDX_BREAK_FLAG_CONTROL = 16'hfe03;
    localparam logic [15:0] IDX_PENDING_IRQ_FLAGS_LOW = 16'hfe04;
    localparam logic [15:0] IDX_PENDING_IRQ_FLAGS_MID = 16'hfe05;
    localparam logic [15:0] IDX_PENDING_IRQ_FLAGS_HIGH = 16'hfe06;
    localparam int ADDR_W = 18;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_BREAK_WAIT_EXIT = 1;
    localparam int BIT_BREAK_CLEAR_ENABLE = 7;
    localparam int BIT_RST_POR = 7;
    localparam int BIT_RST_PIN = 6;
    localparam int BIT_RST_WDOG = 5;
    localparam int BIT_RST_BAD_OPCODE = 4;
    localparam int BIT_RST_BAD_FETCH = 3;
    localparam int BIT_RST_MONITOR = 2;
    localparam int BIT_RST_LOW_VOLTAGE = 1;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_RESET_FLAGS = 8'h00;
    localparam logic RST_BREAK_CLEAR_ENABLE = 1'b0;
    localparam logic RST_BREAK_WAIT_EXIT = 1'b0;
    // ----------------------------------------
    // vectors and timing
    // ----------------------------------------
    localparam int NUM_SRC = 16;
    localparam logic [4:0] VEC_SOFT_TRAP = 5'h00;
    localparam int CNT_W = 13;
    localparam int RECOVERY_LONG_CYCLES = 4096;
    localparam int RECOVERY_SHORT_CYCLES = 32;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAIT = 2'b01,
        ST_HALT = 2'b10,
        ST_RECOVER = 2'b11
    } seu_state_t;
endpackage : seu_pkg
`default_nettype wire

// file: verilog/seu_top.sv
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - software trap taken regardless of mask
// - software trap stacks PC, hardware PC-1
// - fixed sixteen-level source priority order
// - low flags register: flags 6..1, bits1:0 zero
// - mid flags register: flags 14..7, reset zero
// - high flags register: flags 16,15 low bits
// - flag reads one while source requests
// - reset sources beat every interrupt
// - break request forces software trap vector
// - break clears allowed only when enabled
// - flag cleared in break stays cleared
// - two-step clears stay protected during break
// - wait/halt clear mask, stop core clock
// - wait: peripherals run, irq wakes next cycle
// - wait left by reset/break; break sets flag
// - watchdog runs in wait unless disabled
// - halt stops all clocks; irq/reset/break wake
// - halt recovery 4096 or 32 cycles
// - counter held cleared during halt
// - writing zero clears break wait-exit flag
// - reset status clears after read
// - power-on sets own flag, clears others
// - latched interrupt not preempted until done or mask cleared
module seu_top
    import seu_pkg::*;
#(
    parameter int REC_LONG = RECOVERY_LONG_CYCLES,
    parameter int REC_SHORT = RECOVERY_SHORT_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources, bit 0 is flag 1
    input wire logic [NUM_SRC-1:0] irq_src,
    // core handshake
    input wire logic cpu_imask,
    input wire logic insn_boundary,
    input wire logic swi_exec,
    input wire logic wait_exec,
    input wire logic halt_exec,
    input wire logic irq_done,
    input wire logic break_req,
    input wire logic break_done,
    // reset source events
    input wire logic por_evt,
    input wire logic pin_rst_evt,
    input wire logic wdog_rst_evt,
    input wire logic bad_opcode_evt,
    input wire logic bad_fetch_evt,
    input wire logic monitor_rst_evt,
    input wire logic low_voltage_evt,
    // option bits
    input wire logic short_recovery_option,
    input wire logic watchdog_disable_option,
    // outputs to core and clocks
    output logic exc_take,
    output logic [4:0] exc_vector,
    output logic exc_pc_minus1,
    output logic imask_clear,
    output logic sys_reset_req,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic wdog_run,
    output logic in_break,
    output logic flag_clear_ok
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [4:0] hi_pri(input logic [NUM_SRC-1:0] p);
        logic [4:0] v;
        v = 5'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                v = 5'(i + 1);
            end
        end
        return v;
    endfunction : hi_pri

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction : hit

    localparam logic [CNT_W-1:0] LIM_LONG = CNT_W'(REC_LONG - 1);
    localparam logic [CNT_W-1:0] LIM_SHORT = CNT_W'(REC_SHORT - 1);

    // ----------------------------------------
    // state
    // ----------------------------------------
    seu_state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [NUM_SRC-1:0] pend_r;
    logic lat_r, lat_nxt;
    logic wake_brk_r, wake_brk_nxt;
    logic wake_rst_r, wake_rst_nxt;
    logic take_nxt, pcm1_nxt, imclr_nxt, rstreq_nxt;
    logic [4:0] vec_nxt;
    logic cpu_en_nxt, per_en_nxt, brk_nxt, bsw_set;
    logic [7:0] rsf_r, rsf_nxt;
    logic break_clear_enable_r, break_clear_enable_nxt, bsw_r, bsw_nxt;
    logic [31:0] rd_nxt;
    logic rdy_nxt, err_nxt;
    logic rst_any, acc, mapped;
    logic [7:0] rst_evts;
    logic [CNT_W-1:0] lim;

    assign rst_evts = {por_evt, pin_rst_evt, wdog_rst_evt, bad_opcode_evt,
                       bad_fetch_evt, monitor_rst_evt, low_voltage_evt, 1'b0};
    assign rst_any = |rst_evts;
    assign lim = short_recovery_option ? LIM_SHORT : LIM_LONG;

    // ----------------------------------------
    // exception and power sequencing
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        lat_nxt = lat_r;
        wake_brk_nxt = wake_brk_r;
        wake_rst_nxt = wake_rst_r;
        take_nxt = 1'b0;
        vec_nxt = exc_vector;
        pcm1_nxt = 1'b0;
        imclr_nxt = 1'b0;
        rstreq_nxt = 1'b0;
        cpu_en_nxt = cpu_clk_en;
        per_en_nxt = periph_clk_en;
        brk_nxt = in_break && !break_done;
        bsw_set = 1'b0;
        // latched request holds off others until serviced or unmasked
        if (lat_r && (irq_done || !cpu_imask)) begin
            lat_nxt = 1'b0;
        end
        unique case (st_r)
            ST_RUN: begin
                if (rst_any) begin
                    rstreq_nxt = 1'b1;
                    lat_nxt = 1'b0;
                end else if (!lat_r && (break_req || swi_exec)) begin
                    take_nxt = 1'b1;
                    vec_nxt = VEC_SOFT_TRAP;
                    lat_nxt = 1'b1;
                    brk_nxt = brk_nxt || break_req;
                end else if (!lat_r && insn_boundary && !cpu_imask && |pend_r) begin
                    take_nxt = 1'b1;
                    vec_nxt = hi_pri(pend_r);
                    pcm1_nxt = 1'b1;
                    lat_nxt = 1'b1;
                end else if (wait_exec) begin
                    st_nxt = ST_WAIT;
                    imclr_nxt = 1'b1;
                    cpu_en_nxt = 1'b0;
                end else if (halt_exec) begin
                    st_nxt = ST_HALT;
                    imclr_nxt = 1'b1;
                    cpu_en_nxt = 1'b0;
                    per_en_nxt = 1'b0;
                    cnt_nxt = '0;
                end
            end
            ST_WAIT: begin
                // mask was cleared on entry, so any pending source wakes
                if (rst_any) begin
                    st_nxt = ST_RUN;
                    cpu_en_nxt = 1'b1;
                    rstreq_nxt = 1'b1;
                end else if (break_req) begin
                    st_nxt = ST_RUN;
                    cpu_en_nxt = 1'b1;
                    bsw_set = 1'b1;
                    take_nxt = 1'b1;
                    vec_nxt = VEC_SOFT_TRAP;
                    lat_nxt = 1'b1;
                    brk_nxt = 1'b1;
                end else if (|pend_r) begin
                    st_nxt = ST_RUN;
                    cpu_en_nxt = 1'b1;
                    take_nxt = 1'b1;
                    vec_nxt = hi_pri(pend_r);
                    pcm1_nxt = 1'b1;
                    lat_nxt = 1'b1;
                end
            end
            ST_HALT: begin
                cnt_nxt = '0;
                if (rst_any || break_req || |pend_r) begin
                    st_nxt = ST_RECOVER;
                    wake_rst_nxt = rst_any;
                    wake_brk_nxt = break_req;
                end
            end
            ST_RECOVER: begin
                cnt_nxt = cnt_r + 1'b1;
                wake_rst_nxt = wake_rst_r || rst_any;
                if (cnt_r >= lim) begin
                    // stacking only once the oscillator has settled
                    st_nxt = ST_RUN;
                    cpu_en_nxt = 1'b1;
                    per_en_nxt = 1'b1;
                    if (wake_rst_nxt) begin
                        rstreq_nxt = 1'b1;
                    end else if (wake_brk_r) begin
                        take_nxt = 1'b1;
                        vec_nxt = VEC_SOFT_TRAP;
                        lat_nxt = 1'b1;
                        brk_nxt = 1'b1;
                    end else if (|pend_r) begin
                        take_nxt = 1'b1;
                        vec_nxt = hi_pri(pend_r);
                        pcm1_nxt = 1'b1;
                        lat_nxt = 1'b1;
                    end
                    wake_rst_nxt = 1'b0;
                    wake_brk_nxt = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RUN;
            cnt_r <= '0;
            pend_r <= '0;
            lat_r <= 1'b0;
            wake_brk_r <= 1'b0;
            wake_rst_r <= 1'b0;
            exc_take <= 1'b0;
            exc_vector <= VEC_SOFT_TRAP;
            exc_pc_minus1 <= 1'b0;
            imask_clear <= 1'b0;
            sys_reset_req <= 1'b0;
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            wdog_run <= 1'b0;
            in_break <= 1'b0;
            flag_clear_ok <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= irq_src;
            lat_r <= lat_nxt;
            wake_brk_r <= wake_brk_nxt;
            wake_rst_r <= wake_rst_nxt;
            exc_take <= take_nxt;
            exc_vector <= vec_nxt;
            exc_pc_minus1 <= pcm1_nxt;
            imask_clear <= imclr_nxt;
            sys_reset_req <= rstreq_nxt;
            cpu_clk_en <= cpu_en_nxt;
            periph_clk_en <= per_en_nxt;
            wdog_run <= !watchdog_disable_option && st_nxt != ST_HALT;
            in_break <= brk_nxt;
            // peripherals also drop a half-done two-step clear while low
            flag_clear_ok <= !brk_nxt || break_clear_enable_nxt;
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    assign acc = psel && penable && pready;
    assign mapped = hit(paddr, IDX_BREAK_STATUS) || hit(paddr, IDX_RESET_SOURCE_STATUS)
        || hit(paddr, IDX_BREAK_FLAG_CONTROL) || hit(paddr, IDX_PENDING_IRQ_FLAGS_LOW)
        || hit(paddr, IDX_PENDING_IRQ_FLAGS_MID) || hit(paddr, IDX_PENDING_IRQ_FLAGS_HIGH);

    always_comb begin
        rsf_nxt = rsf_r;
        break_clear_enable_nxt = break_clear_enable_r;
        bsw_nxt = bsw_r;
        rd_nxt = '0;
        rdy_nxt = psel && !penable;
        err_nxt = psel && !penable && !mapped;
        if (acc && !pwrite && hit(paddr, IDX_RESET_SOURCE_STATUS)) begin
            rsf_nxt = '0;
        end
        if (por_evt) begin
            rsf_nxt = 8'h01 << BIT_RST_POR;
        end else begin
            rsf_nxt = rsf_nxt | rst_evts;
        end
        if (acc && pwrite && hit(paddr, IDX_BREAK_STATUS) && !pwdata[BIT_BREAK_WAIT_EXIT]) begin
            bsw_nxt = 1'b0;
        end
        if (bsw_set) begin
            bsw_nxt = 1'b1;
        end
        if (acc && pwrite && hit(paddr, IDX_BREAK_FLAG_CONTROL)) begin
            break_clear_enable_nxt = pwdata[BIT_BREAK_CLEAR_ENABLE];
        end
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, IDX_BREAK_STATUS)) begin
                rd_nxt[BIT_BREAK_WAIT_EXIT] = bsw_r;
            end
            if (hit(paddr, IDX_RESET_SOURCE_STATUS)) begin
                rd_nxt[7:0] = rsf_r;
            end
            if (hit(paddr, IDX_BREAK_FLAG_CONTROL)) begin
                rd_nxt[BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_r;
            end
            if (hit(paddr, IDX_PENDING_IRQ_FLAGS_LOW)) begin
                rd_nxt[7:0] = {pend_r[5:0], 2'b00};
            end
            if (hit(paddr, IDX_PENDING_IRQ_FLAGS_MID)) begin
                rd_nxt[7:0] = pend_r[13:6];
            end
            if (hit(paddr, IDX_PENDING_IRQ_FLAGS_HIGH)) begin
                rd_nxt[7:0] = {6'h00, pend_r[15:14]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsf_r <= RST_RESET_FLAGS;
            break_clear_enable_r <= RST_BREAK_CLEAR_ENABLE;
            bsw_r <= RST_BREAK_WAIT_EXIT;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            rsf_r <= rsf_nxt;
            break_clear_enable_r <= break_clear_enable_nxt;
            bsw_r <= bsw_nxt;
            prdata <= rd_nxt;
            pready <= rdy_nxt;
            pslverr <= err_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_recov_start;
        st_r == ST_RECOVER && cnt_r == '0 && short_recovery_option;
    endsequence
    sequence s_recov_body;
        ##30 st_r == ST_RECOVER ##2 st_r == ST_RUN;
    endsequence

    chk_swi_unmasked: assert property (
        st_r == ST_RUN && swi_exec && !lat_r && !rst_any && !break_req
        |=> exc_take && exc_vector == VEC_SOFT_TRAP)
        else $error("software trap not taken");
    chk_pc_adjust: assert property (
        exc_take |-> exc_pc_minus1 == (exc_vector != VEC_SOFT_TRAP))
        else $error("stacked pc adjustment wrong");
    chk_prio_order: assert property (
        exc_take && exc_pc_minus1 |-> exc_vector == hi_pri($past(pend_r)))
        else $error("wrong priority vector");
    chk_low_zero: assert property (
        psel && !penable && !pwrite && hit(paddr, IDX_PENDING_IRQ_FLAGS_LOW)
        |=> prdata[1:0] == 2'b00 && prdata[7:2] == $past(pend_r[5:0]))
        else $error("low flags register wrong");
    chk_pend_track: assert property (
        ##1 pend_r == $past(irq_src))
        else $error("pending flags stale");
    chk_reset_first: assert property (
        st_r == ST_RUN && rst_any |=> sys_reset_req && !exc_take)
        else $error("reset lost to interrupt");
    chk_break_protect: assert property (
        in_break && !break_clear_enable_r |-> !flag_clear_ok)
        else $error("flags unprotected in break");
    chk_wait_wake: assert property (
        st_r == ST_WAIT && |pend_r && !rst_any && !break_req
        |=> exc_take && cpu_clk_en)
        else $error("wait wake late");
    chk_halt_clocks: assert property (
        st_r == ST_HALT |-> !cpu_clk_en && !periph_clk_en && cnt_r == '0)
        else $error("halt clocks or counter active");
    chk_recov_short: assert property (
        s_recov_start |-> s_recov_body)
        else $error("short recovery length wrong");
    chk_rsr_clear: assert property (
        acc && !pwrite && hit(paddr, IDX_RESET_SOURCE_STATUS) && !rst_any
        |=> rsf_r == 8'h00)
        else $error("reset status not cleared");
endmodule : seu_top
`default_nettype wire

// file: testbench/seu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// core model: instruction boundaries, service done
// ----------------------------------------
module seu_core_model #(
    parameter int DONE_DLY = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // from block
    input wire logic cpu_clk_en,
    input wire logic exc_take,
    // to block
    output logic insn_boundary,
    output logic irq_done
);
    logic [1:0] ph_r;
    int svc_r;
    // an unclocked core completes no instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= 2'h0;
            insn_boundary <= 1'b0;
        end else begin
            ph_r <= cpu_clk_en ? ph_r + 2'h1 : ph_r;
            insn_boundary <= cpu_clk_en && (ph_r == 2'h3);
        end
    end
    // slow service so a latched exception stays latched for a while
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_r <= 0;
            irq_done <= 1'b0;
        end else begin
            svc_r <= exc_take ? DONE_DLY : (svc_r > 0 ? svc_r - 1 : 0);
            irq_done <= (svc_r == 1);
        end
    end
endmodule : seu_core_model
`default_nettype wire

// file: testbench/seu_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module seu_top_tb;
    import seu_pkg::*;
    localparam int RL = 64;
    localparam int RS = 32;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_SRC-1:0] irq_src;
    logic cpu_imask, insn_boundary, irq_done, break_req, break_done, sro, wdo;
    logic [2:0] cmd;
    logic [6:0] evt;
    logic exc_take, exc_pc_minus1, imask_clear, sys_reset_req, cpu_clk_en, periph_clk_en;
    logic wdog_run, in_break, flag_clear_ok;
    logic [4:0] exc_vector;
    int n_errors, total_checks, n;

    seu_top #(.REC_LONG(RL), .REC_SHORT(RS)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .irq_src, .cpu_imask, .insn_boundary, .swi_exec(cmd[0]), .wait_exec(cmd[1]),
        .halt_exec(cmd[2]), .irq_done, .break_req, .break_done, .por_evt(evt[0]),
        .pin_rst_evt(evt[1]), .wdog_rst_evt(evt[2]), .bad_opcode_evt(evt[3]),
        .bad_fetch_evt(evt[4]), .monitor_rst_evt(evt[5]), .low_voltage_evt(evt[6]),
        .short_recovery_option(sro), .watchdog_disable_option(wdo), .exc_take, .exc_vector,
        .exc_pc_minus1, .imask_clear, .sys_reset_req, .cpu_clk_en, .periph_clk_en, .wdog_run,
        .in_break, .flag_clear_ok
    );
    seu_core_model #(.DONE_DLY(20)) core (
        .pclk, .presetn, .cpu_clk_en, .exc_take, .insn_boundary, .irq_done
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse_cmd(input logic [2:0] v);
        @(posedge pclk);
        cmd <= v;
        @(posedge pclk);
        cmd <= 3'h0;
    endtask : pulse_cmd
    task automatic pulse_evt(input logic [6:0] v);
        @(posedge pclk);
        evt <= v;
        @(posedge pclk);
        evt <= 7'h00;
        @(posedge pclk);
        chk(sys_reset_req, 1'b1);
    endtask : pulse_evt
    task automatic pulse_brk(input logic done);
        @(posedge pclk);
        if (done) break_done <= 1'b1;
        else break_req <= 1'b1;
        @(posedge pclk);
        break_done <= 1'b0;
        break_req <= 1'b0;
    endtask : pulse_brk
    task automatic wait_take;
        n = 0;
        @(posedge pclk);
        while (exc_take !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        chk(exc_take, 1'b1);
    endtask : wait_take

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        finish_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, irq_src, break_req, break_done} = '0;
        {cmd, evt, sro, wdo} = '0;
        cpu_imask = 1'b1;
        n_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // ---------------- reset values, unmapped place ----------------
        apb(1'b0, IDX_BREAK_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, IDX_BREAK_FLAG_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, IDX_PENDING_IRQ_FLAGS_MID, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 16'hfe02, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        // ---------------- pending flags layout ----------------
        irq_src <= 16'hffff;
        apb(1'b1, IDX_PENDING_IRQ_FLAGS_MID, 32'h00);
        apb(1'b0, IDX_PENDING_IRQ_FLAGS_LOW, 32'h0);
        chk(rd, 32'hfc);
        apb(1'b0, IDX_PENDING_IRQ_FLAGS_MID, 32'h0);
        chk(rd, 32'hff);
        apb(1'b0, IDX_PENDING_IRQ_FLAGS_HIGH, 32'h0);
        chk(rd, 32'h03);
        irq_src <= 16'h8041;
        apb(1'b0, IDX_PENDING_IRQ_FLAGS_LOW, 32'h0);
        chk(rd, 32'h04);
        apb(1'b0, IDX_PENDING_IRQ_FLAGS_MID, 32'h0);
        chk(rd, 32'h01);
        apb(1'b0, IDX_PENDING_IRQ_FLAGS_HIGH, 32'h0);
        chk(rd, 32'h02);
        // ---------------- priority, latching, software trap ----------------
        irq_src <= 16'h0024;
        // let the new sources reach the flags before unmasking
        @(posedge pclk);
        cpu_imask <= 1'b0;
        wait_take();
        chk({exc_vector, exc_pc_minus1}, {5'h03, 1'b1});
        // mask stays clear, so the latch drops and the next source follows
        irq_src <= 16'h0021;
        wait_take();
        chk(exc_vector, 5'h01);
        irq_src <= 16'h0000;
        cpu_imask <= 1'b1;
        repeat (24) @(posedge pclk);
        pulse_cmd(3'h1);
        wait_take();
        chk({exc_vector, exc_pc_minus1}, {VEC_SOFT_TRAP, 1'b0});
        // masked core: a second trap must wait until service is done
        pulse_cmd(3'h1);
        repeat (8) begin
            @(posedge pclk);
            chk(exc_take, 1'b0);
        end
        repeat (24) @(posedge pclk);
        // ---------------- reset source flags ----------------
        for (int i = 1; i < 7; i++) begin
            pulse_evt(7'h01 << i);
            apb(1'b0, IDX_RESET_SOURCE_STATUS, 32'h0);
            chk(rd, 32'h80 >> i);
        end
        pulse_evt(7'h06);
        apb(1'b0, IDX_RESET_SOURCE_STATUS, 32'h0);
        chk(rd, 32'h60);
        apb(1'b0, IDX_RESET_SOURCE_STATUS, 32'h0);
        chk(rd, 32'h00);
        pulse_evt(7'h02);
        pulse_evt(7'h01);
        apb(1'b0, IDX_RESET_SOURCE_STATUS, 32'h0);
        chk(rd, 32'h80);
        // ---------------- break and flag protection ----------------
        apb(1'b1, IDX_BREAK_FLAG_CONTROL, 32'h80);
        apb(1'b0, IDX_BREAK_FLAG_CONTROL, 32'h0);
        chk(rd, 32'h80);
        pulse_brk(1'b0);
        wait_take();
        chk({exc_vector, exc_pc_minus1}, {VEC_SOFT_TRAP, 1'b0});
        @(posedge pclk);
        chk({in_break, flag_clear_ok}, 2'b11);
        apb(1'b1, IDX_BREAK_FLAG_CONTROL, 32'h00);
        repeat (2) @(posedge pclk);
        chk(flag_clear_ok, 1'b0);
        pulse_brk(1'b1);
        repeat (2) @(posedge pclk);
        chk({in_break, flag_clear_ok}, 2'b01);
        repeat (24) @(posedge pclk);
        // ---------------- wait mode ----------------
        pulse_cmd(3'h2);
        @(posedge pclk);
        chk(imask_clear, 1'b1);
        cpu_imask <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({cpu_clk_en, periph_clk_en, wdog_run}, 3'b011);
        irq_src <= 16'h0010;
        wait_take();
        chk(exc_vector, 5'h05);
        irq_src <= 16'h0000;
        repeat (24) @(posedge pclk);
        chk(cpu_clk_en, 1'b1);
        pulse_cmd(3'h2);
        repeat (3) @(posedge pclk);
        pulse_brk(1'b0);
        wait_take();
        chk(exc_vector, VEC_SOFT_TRAP);
        apb(1'b0, IDX_BREAK_STATUS, 32'h0);
        chk({rd[BIT_BREAK_WAIT_EXIT], in_break}, 2'b11);
        apb(1'b1, IDX_BREAK_STATUS, 32'h0);
        apb(1'b0, IDX_BREAK_STATUS, 32'h0);
        chk(rd, 32'h0);
        pulse_brk(1'b1);
        repeat (24) @(posedge pclk);
        // ---------------- halt and recovery ----------------
        for (int s = 0; s < 2; s++) begin
            sro <= s[0];
            pulse_cmd(3'h4);
            repeat (4) @(posedge pclk);
            chk({cpu_clk_en, periph_clk_en}, 2'b00);
            irq_src <= 16'h0001;
            wait_take();
            chk(n >= (s ? RS : RL) && n <= (s ? RS : RL) + 6, 1'b1);
            chk(exc_vector, 5'h01);
            irq_src <= 16'h0000;
            repeat (24) @(posedge pclk);
        end
        wdo <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(wdog_run, 1'b0);
        finish_test();
    end
endmodule : seu_top_tb
`default_nettype wire
